// ### design/owdu_pkg.sv
// Operation
// - frame: start, eight data, even parity, two stops
// - flag wrong parity or stop bits as error
// - parity disable input skips the parity check
// - idle is twelve or more high bits
// - twelve low bits is break, resets link
// - sync expected before instructions and after break
// - acknowledge frame sent once store gains bus
// - debugger waits for acknowledge after a store
// - debugger starts all traffic, leading with sync
// - measured rate used for receive and transmit
// - no writable baud register, sync sets rate
// - divider select: 1=16, 2=8, 3=4 MHz
// - debugger keeps baud inside recommended band
// - fractional bit counting minimises rate error
// - receiver tolerates +4.76/-3.61 percent error
// - debugger sends two breaks back to back
// - break while busy aborts as frame/contention error
// - break restores divider select to 4 MHz
// - debugger break lasts 24.60 ms when unknown
// - sync character is a normal frame, 0x55
// - good sync enables the link again
// - repeat: sync only before first repetition
// - link clock starts at 4 MHz on enable/reset
`default_nettype none
package owdu_pkg;
    // ------------------------------------------------------------
    // clocking
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam logic [7:0]  LTICK_WRAP    = 8'hC8; // 200 MHz expressed in MHz
    localparam logic [7:0]  LTICK_STEP_16 = 8'h10;
    localparam logic [7:0]  LTICK_STEP_8  = 8'h08;
    localparam logic [7:0]  LTICK_STEP_4  = 8'h04;
    localparam logic [1:0]  CLKSEL_16M    = 2'h1;
    localparam logic [1:0]  CLKSEL_8M     = 2'h2;
    localparam logic [1:0]  CLKSEL_4M     = 2'h3;
    localparam logic [1:0]  CLKSEL_DEFAULT = CLKSEL_4M;
    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam logic [7:0]  SYNC_CHAR     = 8'h55;
    localparam logic [7:0]  ACK_CHAR      = 8'h40;
    localparam logic [3:0]  POS_START     = 4'h0;
    localparam logic [3:0]  POS_D0        = 4'h1;
    localparam logic [3:0]  POS_D7        = 4'h8;
    localparam logic [3:0]  POS_PAR       = 4'h9;
    localparam logic [3:0]  POS_STOP1     = 4'hA;
    localparam logic [3:0]  POS_STOP2     = 4'hB;
    localparam logic [2:0]  SYNC_LAST_FALL = 3'h3; // falls after start edge, minus one
    localparam logic [16:0] FRAC_STEP     = 17'h00008; // sync span holds eight bits
    localparam logic [17:0] BRK_UNSYNC_TICKS = 18'h17FF4; // 12 bits of slowest sync
    // ------------------------------------------------------------
    // debugger timing
    // ------------------------------------------------------------
    localparam int unsigned BREAK_NS_4   = 24600000;
    localparam int unsigned BREAK_CYC    = (BREAK_NS_4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HOST_BIT_NS  = 8680;
    localparam int unsigned HOST_BIT_CYC = HOST_BIT_NS / CLK_PERIOD_NS;
    localparam logic [1:0]  CMD_BYTE      = 2'h0;
    localparam logic [1:0]  CMD_SYNC_BYTE = 2'h1;
    localparam logic [1:0]  CMD_SYNC      = 2'h2;
    localparam logic [1:0]  CMD_BREAK     = 2'h3;

    typedef enum logic [2:0] {
        DST_WAIT_SYNC, DST_MEAS, DST_IDLE, DST_RX, DST_TX, DST_ERR
    } owdu_dev_st_e;

    typedef enum logic [2:0] {
        HST_IDLE, HST_TX, HST_BRK, HST_GAP, HST_ACKW
    } owdu_host_st_e;
endpackage : owdu_pkg
`default_nettype wire

// ### design/owdu_link_if.sv
`default_nettype none
interface owdu_link_if;
    logic dev_o;
    logic dev_oe;
    logic host_o;
    logic host_oe;
    logic line;
    // pulled-up line: any enabled low driver wins
    assign line = (dev_oe ? dev_o : 1'b1) & (host_oe ? host_o : 1'b1);
    modport dev  (input line, output dev_o, output dev_oe);
    modport host (input line, output host_o, output host_oe);
endinterface : owdu_link_if
`default_nettype wire

// ### design/owdu_dev.sv
`default_nettype none
module owdu_dev
    import owdu_pkg::*;
#(
    parameter logic [17:0] BRK_TICKS = BRK_UNSYNC_TICKS
)(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    owdu_link_if.dev        link,
    input  wire logic       parity_check_disable,
    input  wire logic       clk_sel_we,
    input  wire logic [1:0] clk_sel_wdata,
    input  wire logic       link_disable,
    input  wire logic       expect_sync,
    input  wire logic       ack_req,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    output logic            err_parity,
    output logic            err_frame,
    output logic            err_contention,
    output logic            break_det,
    output logic            link_enabled,
    output logic [1:0]      link_clock_divider_select
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        owdu_dev_st_e st;
        logic [7:0]   lacc;
        logic         s1;
        logic         s2;
        logic         s3;
        logic         filt;
        logic         prev;
        logic [17:0]  low_cnt;
        logic         brk_hold;
        logic [15:0]  total;
        logic [16:0]  acc;
        logic [3:0]   pos;
        logic [2:0]   falls;
        logic [7:0]   sh;
        logic         par_bad;
        logic         stop_bad;
        logic         is_sync;
        logic         ack_pend;
        logic         link_en;
        logic [1:0]   sel;
        logic         line_o;
        logic         line_oe;
        logic         tx_ready;
        logic [7:0]   rx_data;
        logic         rx_valid;
        logic         err_parity;
        logic         err_frame;
        logic         err_contention;
        logic         break_det;
    } owdu_dev_s;

    owdu_dev_s   q;
    owdu_dev_s   d;
    logic [7:0]  step;
    logic [8:0]  lsum;
    logic        tick;
    logic        fall;
    logic [16:0] asum;
    logic [16:0] half;
    logic        bit_hit;
    logic        mid;
    logic [18:0] low2;
    logic [18:0] tot3;
    logic        thr;
    logic [3:0]  np;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.rx_valid = 1'b0;
        d.err_parity = 1'b0;
        d.err_frame = 1'b0;
        d.err_contention = 1'b0;
        d.break_det = 1'b0;
        np = q.pos + 4'h1;
        // three-stage pin sampler; a level counts once stages two and three agree
        d.s1 = link.line;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 == q.s3) begin
            d.filt = q.s3;
        end
        d.prev = q.filt;
        fall = q.prev & ~q.filt;
        // link clock as a tick from a phase accumulator; 16 MHz is no integer divide of 200
        case (q.sel)
            CLKSEL_16M: step = LTICK_STEP_16;
            CLKSEL_8M:  step = LTICK_STEP_8;
            default:    step = LTICK_STEP_4;
        endcase
        lsum = {1'b0, q.lacc} + {1'b0, step};
        tick = lsum >= {1'b0, LTICK_WRAP};
        d.lacc = tick ? lsum[7:0] - LTICK_WRAP : lsum[7:0];
        // fractional bit timing: remainder carries into the next bit, so no drift
        asum = q.acc + FRAC_STEP;
        bit_hit = tick && (asum >= {1'b0, q.total});
        half = {2'b0, q.total[15:1]};
        mid = tick && (q.acc < half) && (asum >= half);
        if (tick) begin
            d.acc = bit_hit ? asum - {1'b0, q.total} : asum;
        end
        // low-run meter for break; threshold 12 bits = 1.5 x the eight-bit sync span
        low2 = {q.low_cnt, 1'b0};
        tot3 = {3'b0, q.total} + {2'b0, q.total, 1'b0};
        thr = q.link_en ? (low2 >= tot3) : (q.low_cnt >= BRK_TICKS);
        if (q.filt) begin
            d.low_cnt = '0;
            d.brk_hold = 1'b0;
        end else if (tick && !(&q.low_cnt)) begin
            d.low_cnt = q.low_cnt + 18'h00001;
        end
        d.ack_pend = q.ack_pend | ack_req;
        if (clk_sel_we) begin
            d.sel = clk_sel_wdata;
        end
        // frame sequencer
        case (q.st)
            DST_WAIT_SYNC: begin
                if (fall) begin
                    d.st = DST_MEAS;
                    d.acc = '0;
                    d.falls = '0;
                end
            end
            DST_MEAS: begin
                if (fall) begin
                    d.falls = q.falls + 3'h1;
                    if (q.falls == SYNC_LAST_FALL) begin
                        // start of data bit 7: lock the rate and check the tail as a frame
                        d.total = q.acc[15:0];
                        d.acc = {2'b0, q.acc[15:1]};
                        d.pos = POS_D7;
                        d.sh = {SYNC_CHAR[6:0], 1'b0};
                        d.is_sync = 1'b1;
                        d.par_bad = 1'b0;
                        d.stop_bad = 1'b0;
                        d.st = DST_RX;
                    end
                end else if (tick) begin
                    d.acc = q.acc + 17'h00001;
                    if (q.acc[16]) begin
                        d.st = DST_WAIT_SYNC;
                    end
                end
            end
            DST_IDLE: begin
                if (expect_sync) begin
                    d.st = DST_WAIT_SYNC;
                end else if (q.ack_pend) begin
                    d.st = DST_TX;
                    d.sh = ACK_CHAR;
                    d.ack_pend = ack_req;
                end else if (tx_valid && q.tx_ready) begin
                    d.st = DST_TX;
                    d.sh = tx_data;
                end else if (fall) begin
                    d.st = DST_RX;
                    d.pos = POS_START;
                    d.acc = half;
                    d.is_sync = 1'b0;
                    d.par_bad = 1'b0;
                    d.stop_bad = 1'b0;
                end
                if (d.st == DST_TX) begin
                    d.pos = POS_START;
                    d.acc = '0;
                    d.line_oe = 1'b1;
                    d.line_o = 1'b0;
                end
            end
            DST_RX: begin
                if (bit_hit) begin
                    d.pos = np;
                    if (q.pos == POS_START) begin
                        if (q.filt) begin
                            d.st = DST_IDLE;
                        end
                    end else if (q.pos <= POS_D7) begin
                        d.sh = {q.filt, q.sh[7:1]};
                    end else if (q.pos == POS_PAR) begin
                        d.par_bad = !parity_check_disable && (q.filt != ^q.sh);
                    end else if (q.pos == POS_STOP1) begin
                        d.stop_bad = ~q.filt;
                    end else begin
                        if (q.stop_bad || !q.filt) begin
                            d.err_frame = 1'b1;
                            d.st = DST_ERR;
                        end else if (q.par_bad) begin
                            d.err_parity = 1'b1;
                            d.st = DST_ERR;
                        end else if (q.is_sync) begin
                            d.link_en = 1'b1;
                            d.st = DST_IDLE;
                        end else begin
                            d.rx_data = q.sh;
                            d.rx_valid = 1'b1;
                            d.st = DST_IDLE;
                        end
                    end
                end
            end
            DST_TX: begin
                if (mid && (q.filt != q.line_o)) begin
                    d.err_contention = 1'b1;
                    d.st = DST_ERR;
                    d.line_oe = 1'b0;
                    d.line_o = 1'b1;
                end else if (bit_hit) begin
                    d.pos = np;
                    if (q.pos == POS_STOP2) begin
                        d.st = DST_IDLE;
                        d.line_oe = 1'b0;
                        d.line_o = 1'b1;
                    end else if (np <= POS_D7) begin
                        d.line_o = q.sh[3'(np - POS_D0)];
                    end else if (np == POS_PAR) begin
                        d.line_o = ^q.sh;
                    end else begin
                        d.line_o = 1'b1;
                    end
                end
            end
            default: begin
                // error: wait here for a break
            end
        endcase
        // break only outside reception and transmission; busy cases end in error first
        if (thr && !q.brk_hold && (q.st != DST_RX) && (q.st != DST_TX)) begin
            d.break_det = 1'b1;
            d.brk_hold = 1'b1;
            d.st = DST_WAIT_SYNC;
            d.link_en = 1'b0;
            d.sel = CLKSEL_DEFAULT;
            d.ack_pend = ack_req;
            d.line_oe = 1'b0;
            d.line_o = 1'b1;
        end
        if (link_disable) begin
            d.st = DST_WAIT_SYNC;
            d.link_en = 1'b0;
            d.sel = CLKSEL_DEFAULT;
            d.ack_pend = 1'b0;
            d.line_oe = 1'b0;
            d.line_o = 1'b1;
        end
        d.tx_ready = (d.st == DST_IDLE) && !d.ack_pend;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
            q.sel <= CLKSEL_DEFAULT;
            q.s1 <= 1'b1;
            q.s2 <= 1'b1;
            q.s3 <= 1'b1;
            q.filt <= 1'b1;
            q.prev <= 1'b1;
            q.line_o <= 1'b1;
        end else if (ce) begin
            q <= d;
        end
    end

    // outputs straight from the state flops
    assign link.dev_o = q.line_o;
    assign link.dev_oe = q.line_oe;
    assign tx_ready = q.tx_ready;
    assign rx_data = q.rx_data;
    assign rx_valid = q.rx_valid;
    assign err_parity = q.err_parity;
    assign err_frame = q.err_frame;
    assign err_contention = q.err_contention;
    assign break_det = q.break_det;
    assign link_enabled = q.link_en;
    assign link_clock_divider_select = q.sel;
endmodule : owdu_dev
`default_nettype wire

// ### design/owdu_host.sv
`default_nettype none
module owdu_host
    import owdu_pkg::*;
#(
    parameter int unsigned BRK_CYC = BREAK_CYC,
    parameter int unsigned BIT_CYC = HOST_BIT_CYC
)(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    owdu_link_if.host       link,
    input  wire logic       cmd_valid,
    input  wire logic [1:0] cmd_kind,
    input  wire logic [7:0] cmd_data,
    input  wire logic       cmd_wait_ack,
    output logic            cmd_ready,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    output logic            rx_err
);
    typedef struct packed {
        owdu_host_st_e st;
        logic [23:0]   cnt;
        logic [3:0]    pos;
        logic [7:0]    sh;
        logic [7:0]    byte_q;
        logic          then_byte;
        logic          wait_ack;
        logic          brk2;
        logic          s1;
        logic          s2;
        logic          s3;
        logic          filt;
        logic          prev;
        logic          rx_on;
        logic [23:0]   rcnt;
        logic [3:0]    rpos;
        logic [7:0]    rsh;
        logic          rbad;
        logic          line_o;
        logic          line_oe;
        logic          cmd_ready;
        logic [7:0]    rx_data;
        logic          rx_valid;
        logic          rx_err;
    } owdu_host_s;

    localparam logic [23:0] BIT_LAST = 24'(BIT_CYC - 1);
    localparam logic [23:0] BIT_HALF = 24'(BIT_CYC / 2);
    localparam logic [23:0] BRK_LAST = 24'(BRK_CYC - 1);

    owdu_host_s q;
    owdu_host_s d;
    logic [3:0] np;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.rx_valid = 1'b0;
        d.rx_err = 1'b0;
        np = q.pos + 4'h1;
        d.s1 = link.line;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 == q.s3) begin
            d.filt = q.s3;
        end
        d.prev = q.filt;
        if (q.cnt != '0) begin
            d.cnt = q.cnt - 24'h000001;
        end
        // receiver for device replies; own frames are not listened to
        if (!q.rx_on) begin
            if (q.prev && !q.filt && !q.line_oe) begin
                d.rx_on = 1'b1;
                d.rcnt = BIT_HALF;
                d.rpos = POS_START;
                d.rbad = 1'b0;
            end
        end else if (q.rcnt != '0) begin
            d.rcnt = q.rcnt - 24'h000001;
        end else begin
            d.rcnt = BIT_LAST;
            d.rpos = q.rpos + 4'h1;
            if (q.rpos == POS_START) begin
                d.rx_on = ~q.filt;
            end else if (q.rpos <= POS_D7) begin
                d.rsh = {q.filt, q.rsh[7:1]};
            end else if (q.rpos == POS_PAR) begin
                d.rbad = q.filt != ^q.rsh;
            end else if (q.rpos == POS_STOP1) begin
                d.rbad = q.rbad | ~q.filt;
            end else begin
                d.rx_on = 1'b0;
                d.rx_data = q.rsh;
                d.rx_valid = !q.rbad && q.filt;
                d.rx_err = q.rbad || !q.filt;
            end
        end
        case (q.st)
            HST_IDLE: begin
                if (cmd_valid) begin
                    d.wait_ack = cmd_wait_ack;
                    d.byte_q = cmd_data;
                    d.then_byte = (cmd_kind == CMD_SYNC_BYTE);
                    d.line_oe = 1'b1;
                    d.line_o = 1'b0;
                    if (cmd_kind == CMD_BREAK) begin
                        d.st = HST_BRK;
                        d.cnt = BRK_LAST;
                        d.brk2 = 1'b0;
                    end else begin
                        d.st = HST_TX;
                        d.sh = (cmd_kind == CMD_BYTE) ? cmd_data : SYNC_CHAR;
                        d.cnt = BIT_LAST;
                        d.pos = POS_START;
                    end
                end
            end
            HST_TX: begin
                if (q.cnt == '0) begin
                    d.cnt = BIT_LAST;
                    d.pos = np;
                    if (q.pos == POS_STOP2) begin
                        if (q.then_byte) begin
                            d.then_byte = 1'b0;
                            d.sh = q.byte_q;
                            d.pos = POS_START;
                            d.line_o = 1'b0;
                        end else begin
                            d.line_oe = 1'b0;
                            d.st = q.wait_ack ? HST_ACKW : HST_IDLE;
                        end
                    end else if (np <= POS_D7) begin
                        d.line_o = q.sh[3'(np - POS_D0)];
                    end else if (np == POS_PAR) begin
                        d.line_o = ^q.sh;
                    end else begin
                        d.line_o = 1'b1;
                    end
                end
            end
            HST_BRK: begin
                if (q.cnt == '0) begin
                    d.st = HST_GAP;
                    d.cnt = BIT_LAST;
                    d.line_o = 1'b1;
                    d.line_oe = 1'b0;
                end
            end
            HST_GAP: begin
                if (q.cnt == '0) begin
                    if (q.brk2) begin
                        d.st = HST_IDLE;
                    end else begin
                        d.st = HST_BRK;
                        d.brk2 = 1'b1;
                        d.cnt = BRK_LAST;
                        d.line_o = 1'b0;
                        d.line_oe = 1'b1;
                    end
                end
            end
            default: begin
                if (q.rx_valid || q.rx_err) begin
                    d.st = HST_IDLE;
                end
            end
        endcase
        d.cmd_ready = (d.st == HST_IDLE);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
            q.s1 <= 1'b1;
            q.s2 <= 1'b1;
            q.s3 <= 1'b1;
            q.filt <= 1'b1;
            q.prev <= 1'b1;
            q.line_o <= 1'b1;
        end else if (ce) begin
            q <= d;
        end
    end

    assign link.host_o = q.line_o;
    assign link.host_oe = q.line_oe;
    assign cmd_ready = q.cmd_ready;
    assign rx_data = q.rx_data;
    assign rx_valid = q.rx_valid;
    assign rx_err = q.rx_err;
endmodule : owdu_host
`default_nettype wire

// ### testbench/owdu_link_monitor.sv
`default_nettype none
module owdu_link_monitor #(
    parameter int unsigned BIT_CYC = 400
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic dev_o,
    input wire logic dev_oe,
    input wire logic host_o,
    input wire logic host_oe,
    input wire logic line
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned LEN_LO = 12 * BIT_CYC - BIT_CYC / 2;
    localparam int unsigned LEN_HI = 12 * BIT_CYC + BIT_CYC / 2;
    logic [15:0] len_q;
    // ------------------------------------------------------------
    // frame length counter
    // ------------------------------------------------------------
    // counts device drive cycles; judged when the drive ends
    always_ff @(posedge clk) begin
        len_q <= dev_oe ? len_q + 16'h0001 : 16'h0000;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_dev_start; $rose(dev_oe) |-> !dev_o [*8]; endproperty
    property p_dev_hold; $rose(dev_oe) |=> dev_oe [*8]; endproperty
    property p_dev_len; $fell(dev_oe) |-> len_q >= LEN_LO && len_q <= LEN_HI; endproperty
    property p_dev_stop; $fell(dev_oe) |-> $past(dev_o) && $past(dev_o, 8); endproperty
    property p_host_start; $rose(host_oe) |-> !host_o [*8]; endproperty
    property p_half_dup; dev_oe |-> !host_oe; endproperty
    property p_idle_high; !dev_oe && !host_oe |-> line; endproperty
    property p_rst_quiet; $fell(rst) |-> !dev_oe && !host_oe; endproperty
    a_dev_start: assert property (p_dev_start) else $error("device frame without low start");
    a_dev_hold: assert property (p_dev_hold) else $error("device drive too short");
    a_dev_len: assert property (p_dev_len) else $error("device frame length off");
    a_dev_stop: assert property (p_dev_stop) else $error("device stop bits not high");
    a_host_start: assert property (p_host_start) else $error("host frame without low start");
    a_half_dup: assert property (p_half_dup) else $error("both ends driving");
    a_idle_high: assert property (p_idle_high) else $error("released line not high");
    a_rst_quiet: assert property (p_rst_quiet) else $error("driver active after reset");
    c_dev_tx: cover property ($rose(dev_oe));
    c_host_tx: cover property ($rose(host_oe));
    c_long_low: cover property (!line [*8]);
endmodule : owdu_link_monitor
`default_nettype wire

// ### testbench/test_one_wire_debug_uart_phy.sv
`default_nettype none
module test_one_wire_debug_uart_phy
    import owdu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned BIT = 400; // eight link ticks per bit at 4 MHz
    logic       clk = 1'b0, rst = 1'b1, pcd = 1'b0, sel_we = 1'b0, ack_req = 1'b0, ce = 1'b1, txv = 1'b0;
    logic [1:0] sel_wd = 2'h0, kind = 2'h0, sel;
    logic       cmd_valid = 1'b0, wait_ack = 1'b0, cmd_ready, d_rxv, h_rxv, h_err;
    logic [7:0] data = 8'h00, d_rx, h_rx;
    logic       tx_ready, e_par, e_frm, e_con, brk, link_en;
    int         ev[4] = '{0, 0, 0, 0}, fails = 0, cmp_count = 0;
    owdu_link_if link_if();
    owdu_dev #(.BRK_TICKS(18'h00064)) owdu_dev_inst (.clk(clk), .rst(rst), .ce(ce), .link(link_if),
        .parity_check_disable(pcd), .clk_sel_we(sel_we), .clk_sel_wdata(sel_wd), .link_disable(1'b0),
        .expect_sync(1'b0), .ack_req(ack_req), .tx_valid(txv), .tx_data(data), .tx_ready(tx_ready),
        .rx_data(d_rx), .rx_valid(d_rxv), .err_parity(e_par), .err_frame(e_frm), .err_contention(e_con),
        .break_det(brk), .link_enabled(link_en), .link_clock_divider_select(sel));
    owdu_host #(.BRK_CYC(6000), .BIT_CYC(BIT)) owdu_host_inst (.clk(clk), .rst(rst), .ce(ce),
        .link(link_if), .cmd_valid(cmd_valid), .cmd_kind(kind), .cmd_data(data), .cmd_wait_ack(wait_ack),
        .cmd_ready(cmd_ready), .rx_data(h_rx), .rx_valid(h_rxv), .rx_err(h_err));
    owdu_link_monitor #(.BIT_CYC(BIT)) owdu_link_monitor_inst (.clk(clk), .rst(rst),
        .dev_o(link_if.dev_o), .dev_oe(link_if.dev_oe), .host_o(link_if.host_o),
        .host_oe(link_if.host_oe), .line(link_if.line));
    always #2.5 clk = ~clk;
    // ------------------------------------------------------------
    // event tally
    // ------------------------------------------------------------
    // sync bytes are left out so a data byte is not confused with one; unknowns before reset are skipped
    always @(posedge clk) if (!rst) begin
        if (d_rxv === 1'b1 && d_rx !== SYNC_CHAR) ev[0]++;
        if (brk === 1'b1) ev[1]++;
        if (h_rxv === 1'b1) ev[2]++;
        if ((e_par | e_frm | e_con | h_err) !== 1'b0) ev[3]++;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_ev(input int i, input int n);
        for (int k = 0; k < 40000 && ev[i] < n; k++) begin
            @(posedge clk);
            #1;
        end
        check(8'(ev[i] >= n), 8'h01);
    endtask : wait_ev
    // holds the command until the host takes it
    task automatic send(input logic [1:0] k_in, input logic [7:0] d_in, input logic w_in);
        @(posedge clk);
        kind <= k_in;
        data <= d_in;
        wait_ack <= w_in;
        cmd_valid <= 1'b1;
        do @(posedge clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
    endtask : send
    task automatic sync_byte(input logic [7:0] d_in);
        int n = ev[0];
        send(CMD_SYNC_BYTE, d_in, 1'b0);
        wait_ev(0, n + 1);
        check(d_rx, d_in);
        check(8'(link_en), 8'h01);
    endtask : sync_byte
    task automatic t_store_ack();
        int n = ev[0];
        int m = ev[2];
        send(CMD_BYTE, 8'h6E, 1'b1);
        wait_ev(0, n + 1);
        repeat (BIT) @(posedge clk); // the host owns the line until its stop bits end
        ack_req <= 1'b1;
        @(posedge clk);
        ack_req <= 1'b0;
        wait_ev(2, m + 1);
        check(h_rx, ACK_CHAR);
        @(posedge clk);
        data <= 8'h96;
        txv <= 1'b1;
        do @(posedge clk); while (tx_ready !== 1'b1);
        txv <= 1'b0;
        wait_ev(2, m + 2);
        check(h_rx, 8'h96);
        $display("test store_ack done");
    endtask : t_store_ack
    task automatic t_break();
        int n = ev[1];
        repeat (BIT) @(posedge clk); // device stop bits end before the break
        ce <= 1'b0; // a frozen device must ignore the write
        sel_we <= 1'b1;
        sel_wd <= CLKSEL_16M;
        @(posedge clk);
        ce <= 1'b1;
        #1;
        check(8'(sel), 8'(CLKSEL_DEFAULT));
        @(posedge clk);
        sel_we <= 1'b0;
        @(posedge clk);
        #1;
        check(8'(sel), 8'(CLKSEL_16M));
        send(CMD_BREAK, 8'h00, 1'b0);
        wait_ev(1, n + 1);
        check(8'(sel), 8'(CLKSEL_DEFAULT));
        check(8'(link_en), 8'h00);
        pcd <= 1'b1; // checker off must still pass good bytes
        sync_byte(8'h3C);
        $display("test break done");
    endtask : t_break
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    // whole run is near 50k cycles; twice that means a hang
    initial begin
        #500000;
        fails++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        check(8'(sel), 8'(CLKSEL_DEFAULT));
        sync_byte(8'hA5);
        $display("test sync done");
        t_store_ack();
        t_break();
        check(8'(ev[3]), 8'h01);
        tally_and_finish();
    end
endmodule : test_one_wire_debug_uart_phy
`default_nettype wire
